// ===== brc_consts.svh
// Buck regulator control register bank: offsets, field positions, reset values.
// Assumes an 8-bit register port; included by the package and the design module.
`ifndef BRC_CONSTS_SVH
`define BRC_CONSTS_SVH

`define BRC_ADDR_W 8
`define BRC_DATA_W 8
`define BRC_OFS_CORE1 8'h21
`define BRC_OFS_PROC 8'h22
`define BRC_OFS_MEM 8'h23
`define BRC_OFS_IO 8'h24
`define BRC_OFS_PERI 8'h25
`define BRC_RST_VAL 8'h00
`define BRC_UNMAPPED_VAL 8'h00
`define BRC_BIT_EN 0
`define BRC_BIT_PEN_LO 1
`define BRC_BIT_PEN_HI 2
`define BRC_BIT_SEQ 3
`define BRC_BIT_SW 4
`define BRC_BIT_PV_LO 5
`define BRC_BIT_PV_HI 6
`define BRC_BIT_SWSEQ 7
`define BRC_NBUCK 5
`define BRC_IDX_CORE1 0
`define BRC_IDX_PROC 1
`define BRC_IDX_MEM 2
`define BRC_IDX_IO 3
`define BRC_IDX_PERI 4

`endif

// ===== brc_pkg.sv
// Types for the buck regulator control register bank.
// Assumes brc_consts.svh is on the include path.
`include "brc_consts.svh"

package brc_pkg;
   typedef logic [`BRC_ADDR_W-1:0] brc_addr_t;
   typedef logic [`BRC_DATA_W-1:0] brc_data_t;
   typedef logic [`BRC_NBUCK-1:0] brc_vec_t;
   // Pin-control field codes
   typedef enum logic [1:0] {
      BRC_SEL_NONE = 2'h0,
      BRC_SEL_PIN1 = 2'h1,
      BRC_SEL_PIN2 = 2'h2,
      BRC_SEL_PIN13 = 2'h3
   } brc_sel_t;
endpackage : brc_pkg

// ===== brc_regs.sv
// Control register bank for five buck converters and two load switches.
// Assumes a synchronous register port and synchronous pin and sequencer inputs.
`timescale 1ns/1ps
`include "brc_consts.svh"

// How it works
// - Core register bit 4 closes the core load switch when set.
// - Core register bit 3 holds the sequencer target enable for the core buck.
// - Core bits 2:1 choose a pin whose edges enable or disable the core buck.
// - Pin field: 00 none, 01 pin one, 10 pin two, 11 pin thirteen.
// - Core register bit 0 enables the core buck when set.
// - Processor bits 6:5 choose a pin picking voltage A on rise, B on fall.
// - Processor bit 3 holds the sequencer target enable for the processor buck.
// - Processor bits 2:1 choose a pin whose edges enable or disable that buck.
// - Processor bit 0 enables the processor buck when set.
// - Memory bits 6:5 choose a pin picking voltage A on rise, B on fall.
// - Memory bit 3 is the sequencer target, used only as a default supply.
// - Memory bits 2:1 choose a pin whose edges enable or disable that buck.
// - Memory bit 0 enables the memory buck when set.
// - I/O bits 6:5 choose a pin picking voltage A on rise, B on fall.
// - I/O bit 3 holds the sequencer target enable for the I/O buck.
// - I/O bits 2:1 choose a pin whose edges enable or disable that buck.
// - I/O bit 0 enables the I/O buck when set.
// - Peripheral bit 7 holds the sequencer target for the peripheral switch.
// - Peripheral bits 6:5 choose a pin picking voltage A on rise.
// - Core bit 7 holds the sequencer target for the core load switch.
// - Peripheral bit 4 closes the peripheral load switch when set.
module brc_regs (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Register port
   input wire brc_pkg::brc_addr_t reg_addr,
   input wire brc_pkg::brc_data_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output brc_pkg::brc_data_t reg_rdata,
   // General-purpose pin levels
   input wire logic general_pin_one,
   input wire logic general_pin_two,
   input wire logic general_pin_thirteen,
   // Power sequencer: one-cycle pulse applies stored targets
   input wire logic seq_apply,
   input wire logic memory_default_supply,
   // Regulator controls, index 0 core, 1 proc, 2 memory, 3 io, 4 peripheral
   output brc_pkg::brc_vec_t buck_enable,
   output brc_pkg::brc_vec_t buck_select_b,
   output logic core_load_switch,
   output logic periph_load_switch
);
   import brc_pkg::*;

   brc_data_t ctl_reg [`BRC_NBUCK];
   brc_data_t ctl_next [`BRC_NBUCK];
   logic [2:0] pin_prev_reg;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;
   brc_data_t rdata_reg;
   brc_vec_t vsel_reg;

   // Map a register offset to its bank index; out of range means unmapped
   function automatic logic [2:0] addr_index(input brc_addr_t a);
      unique case (a)
         `BRC_OFS_CORE1: addr_index = 3'(`BRC_IDX_CORE1);
         `BRC_OFS_PROC: addr_index = 3'(`BRC_IDX_PROC);
         `BRC_OFS_MEM: addr_index = 3'(`BRC_IDX_MEM);
         `BRC_OFS_IO: addr_index = 3'(`BRC_IDX_IO);
         `BRC_OFS_PERI: addr_index = 3'(`BRC_IDX_PERI);
         default: addr_index = 3'(`BRC_NBUCK);
      endcase
   endfunction : addr_index

   // Field code to one-hot pin mask; none selects nothing
   function automatic logic [2:0] pin_onehot(input logic [1:0] f);
      unique case (brc_sel_t'(f))
         BRC_SEL_PIN1: pin_onehot = 3'h1;
         BRC_SEL_PIN2: pin_onehot = 3'h2;
         BRC_SEL_PIN13: pin_onehot = 3'h4;
         BRC_SEL_NONE: pin_onehot = 3'h0;
      endcase
   endfunction : pin_onehot

   always_comb begin
      pin_rise = {general_pin_thirteen, general_pin_two, general_pin_one} & ~pin_prev_reg;
      pin_fall = ~{general_pin_thirteen, general_pin_two, general_pin_one} & pin_prev_reg;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_prev_reg <= 3'h0;
      end else begin
         pin_prev_reg <= {general_pin_thirteen, general_pin_two, general_pin_one};
      end
   end

   // Next register values: write, then sequencer, then pin edges on enable bit.
   // Pin edges come last so a transition is never lost to a same-cycle write.
   always_comb begin
      for (int i = 0; i < `BRC_NBUCK; i++) begin
         logic [2:0] sel;
         sel = pin_onehot(ctl_reg[i][`BRC_BIT_PEN_HI:`BRC_BIT_PEN_LO]);
         ctl_next[i] = ctl_reg[i];
         if (reg_wr && addr_index(reg_addr) == 3'(i)) begin
            ctl_next[i] = reg_wdata;
         end
         if (seq_apply && (i != `BRC_IDX_MEM || memory_default_supply)) begin
            ctl_next[i][`BRC_BIT_EN] = ctl_reg[i][`BRC_BIT_SEQ];
         end
         if (seq_apply && (i == `BRC_IDX_CORE1 || i == `BRC_IDX_PERI)) begin
            ctl_next[i][`BRC_BIT_SW] = ctl_reg[i][`BRC_BIT_SWSEQ];
         end
         if ((sel & pin_rise) != 3'h0) begin
            ctl_next[i][`BRC_BIT_EN] = 1'b1;
         end else if ((sel & pin_fall) != 3'h0) begin
            ctl_next[i][`BRC_BIT_EN] = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < `BRC_NBUCK; i++) begin
            ctl_reg[i] <= `BRC_RST_VAL;
         end
      end else begin
         for (int i = 0; i < `BRC_NBUCK; i++) begin
            ctl_reg[i] <= ctl_next[i];
         end
      end
   end

   // Voltage choice: A on a rise of the chosen pin, B on a fall; held otherwise
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         vsel_reg <= '0;
      end else begin
         for (int i = 0; i < `BRC_NBUCK; i++) begin
            logic [2:0] vs;
            vs = pin_onehot(ctl_reg[i][`BRC_BIT_PV_HI:`BRC_BIT_PV_LO]);
            if ((vs & pin_rise) != 3'h0) begin
               vsel_reg[i] <= 1'b0;
            end else if ((vs & pin_fall) != 3'h0) begin
               vsel_reg[i] <= 1'b1;
            end
         end
      end
   end

   // Outputs come from flops; they mirror the bank and vsel_reg one cycle late
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         buck_enable <= '0;
         buck_select_b <= '0;
         core_load_switch <= 1'b0;
         periph_load_switch <= 1'b0;
      end else begin
         for (int i = 0; i < `BRC_NBUCK; i++) begin
            buck_enable[i] <= ctl_reg[i][`BRC_BIT_EN];
         end
         buck_select_b <= vsel_reg;
         core_load_switch <= ctl_reg[`BRC_IDX_CORE1][`BRC_BIT_SW];
         periph_load_switch <= ctl_reg[`BRC_IDX_PERI][`BRC_BIT_SW];
      end
   end

   // Read data valid the cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= `BRC_UNMAPPED_VAL;
      end else if (reg_rd && addr_index(reg_addr) < 3'(`BRC_NBUCK)) begin
         rdata_reg <= ctl_reg[addr_index(reg_addr)];
      end else begin
         rdata_reg <= `BRC_UNMAPPED_VAL;
      end
   end

   assign reg_rdata = rdata_reg;

   // Timing of the checks below: a write lands in the bank at its own edge, the
   // output flops copy the bank one edge later, so outputs are looked at two edges on.
   // A sequencer pulse in the write cycle wins the switch bit, hence the guard.
   core_switch_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      reg_wr && reg_addr == `BRC_OFS_CORE1 && !seq_apply
      |-> ##2 core_load_switch == $past(reg_wdata[`BRC_BIT_SW], 2))
      else $error("core load switch does not follow written bit");

   periph_switch_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      reg_wr && reg_addr == `BRC_OFS_PERI && !seq_apply |=> ##1 periph_load_switch == $past(reg_wdata[`BRC_BIT_SW], 2))
      else $error("peripheral switch does not follow written bit");

   core_enable_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      reg_wr && reg_addr == `BRC_OFS_CORE1 && !seq_apply && pin_rise == 3'h0 && pin_fall == 3'h0
      |-> ##2 buck_enable[`BRC_IDX_CORE1] == $past(reg_wdata[`BRC_BIT_EN], 2))
      else $error("core enable does not follow written bit");

   seq_apply_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seq_apply && !reg_wr && pin_rise == 3'h0 && pin_fall == 3'h0
      |=> ctl_reg[`BRC_IDX_PROC][`BRC_BIT_EN] == $past(ctl_reg[`BRC_IDX_PROC][`BRC_BIT_SEQ]))
      else $error("processor sequencer target not applied");

   mem_default_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seq_apply && !memory_default_supply && !reg_wr && pin_rise == 3'h0 && pin_fall == 3'h0
      |=> $stable(ctl_reg[`BRC_IDX_MEM]))
      else $error("memory target applied while not default supply");

   pin_enable_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_IO][`BRC_BIT_PEN_HI:`BRC_BIT_PEN_LO] == 2'h1 && pin_rise[0]
      |-> ##2 buck_enable[`BRC_IDX_IO])
      else $error("pin one rise did not enable io buck");

   pin_disable_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_PROC][`BRC_BIT_PEN_HI:`BRC_BIT_PEN_LO] == 2'h3 && pin_fall[2]
      |-> ##2 !buck_enable[`BRC_IDX_PROC])
      else $error("pin thirteen fall did not disable processor buck");

   volt_select_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_MEM][`BRC_BIT_PV_HI:`BRC_BIT_PV_LO] == 2'h2 && pin_fall[1]
      |-> ##2 buck_select_b[`BRC_IDX_MEM])
      else $error("pin two fall did not select voltage b");

   no_pin_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_CORE1][`BRC_BIT_PV_HI:`BRC_BIT_PV_LO] == 2'h0 |=> $stable(vsel_reg[0]))
      else $error("voltage choice moved without pin control");

   read_back_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      reg_wr && reg_addr == `BRC_OFS_IO && !seq_apply && pin_rise == 3'h0 && pin_fall == 3'h0
      ##1 !reg_wr && !seq_apply && pin_rise == 3'h0 && pin_fall == 3'h0
      ##1 reg_rd && reg_addr == `BRC_OFS_IO && !seq_apply
      |=> reg_rdata == $past(reg_wdata, 3))
      else $error("register did not read back written value");

   // Read data stands only in the cycle after each strobe cycle; software polling must not expect
   // the value to linger, which keeps the port free of stale data.
   rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !reg_rd
      |=> reg_rdata == `BRC_UNMAPPED_VAL)
      else $error("read data present without a read strobe");

   rdata_unmapped_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      reg_rd && addr_index(reg_addr) == 3'(`BRC_NBUCK)
      |=> reg_rdata == `BRC_UNMAPPED_VAL)
      else $error("unmapped offset returned data");

   unmapped_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      reg_wr && addr_index(reg_addr) == 3'(`BRC_NBUCK) && !seq_apply
      && pin_rise == 3'h0 && pin_fall == 3'h0
      |=> $stable(ctl_reg[`BRC_IDX_IO]))
      else $error("write to an unmapped offset changed the bank");

   reserved_store_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      reg_wr && reg_addr == `BRC_OFS_PROC
      |=> ctl_reg[`BRC_IDX_PROC][`BRC_BIT_SWSEQ:`BRC_BIT_PEN_LO]
         == $past(reg_wdata[`BRC_BIT_SWSEQ:`BRC_BIT_PEN_LO]))
      else $error("processor register upper bits not stored");

   core_load_switch_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      reg_wr && reg_addr == `BRC_OFS_CORE1 && !seq_apply
      |=> ctl_reg[`BRC_IDX_CORE1][`BRC_BIT_SW] == $past(reg_wdata[`BRC_BIT_SW]))
      else $error("core switch bit not stored");

   periph_load_switch_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      reg_wr && reg_addr == `BRC_OFS_PERI && !seq_apply
      |=> ctl_reg[`BRC_IDX_PERI][`BRC_BIT_SW] == $past(reg_wdata[`BRC_BIT_SW]))
      else $error("peripheral switch bit not stored");

   // Sequencer pulse copies targets; pin edges outrank it on the enable bit.
   core_seq_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seq_apply && !reg_wr && pin_rise == 3'h0 && pin_fall == 3'h0
      |=> ctl_reg[`BRC_IDX_CORE1][`BRC_BIT_EN] == $past(ctl_reg[`BRC_IDX_CORE1][`BRC_BIT_SEQ]))
      else $error("core sequencer target not applied");

   io_seq_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seq_apply && !reg_wr && pin_rise == 3'h0 && pin_fall == 3'h0
      |=> ctl_reg[`BRC_IDX_IO][`BRC_BIT_EN] == $past(ctl_reg[`BRC_IDX_IO][`BRC_BIT_SEQ]))
      else $error("io sequencer target not applied");

   mem_seq_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seq_apply && memory_default_supply && !reg_wr && pin_rise == 3'h0 && pin_fall == 3'h0
      |=> ctl_reg[`BRC_IDX_MEM][`BRC_BIT_EN] == $past(ctl_reg[`BRC_IDX_MEM][`BRC_BIT_SEQ]))
      else $error("memory sequencer target not applied as default supply");

   core_load_switch_seq_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seq_apply
      |=> ctl_reg[`BRC_IDX_CORE1][`BRC_BIT_SW] == $past(ctl_reg[`BRC_IDX_CORE1][`BRC_BIT_SWSEQ]))
      else $error("core switch target not applied");

   periph_load_switch_seq_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seq_apply
      |=> ctl_reg[`BRC_IDX_PERI][`BRC_BIT_SW] == $past(ctl_reg[`BRC_IDX_PERI][`BRC_BIT_SWSEQ]))
      else $error("peripheral switch target not applied");

   // Pin edges on the enable bit, one field code of each kind at least
   core_pin_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_CORE1][`BRC_BIT_PEN_HI:`BRC_BIT_PEN_LO] == BRC_SEL_PIN1 && pin_fall[0]
      |=> !ctl_reg[`BRC_IDX_CORE1][`BRC_BIT_EN])
      else $error("pin one fall did not clear core enable");

   proc_pin_on_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_PROC][`BRC_BIT_PEN_HI:`BRC_BIT_PEN_LO] == BRC_SEL_PIN2 && pin_rise[1]
      |=> ctl_reg[`BRC_IDX_PROC][`BRC_BIT_EN])
      else $error("pin two rise did not set processor enable");

   mem_pin_on_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_MEM][`BRC_BIT_PEN_HI:`BRC_BIT_PEN_LO] == BRC_SEL_PIN2 && pin_rise[1]
      |=> ctl_reg[`BRC_IDX_MEM][`BRC_BIT_EN])
      else $error("pin two rise did not set memory enable");

   mem_pin_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_MEM][`BRC_BIT_PEN_HI:`BRC_BIT_PEN_LO] == BRC_SEL_PIN1 && pin_fall[0]
      |=> !ctl_reg[`BRC_IDX_MEM][`BRC_BIT_EN])
      else $error("pin one fall did not clear memory enable");

   io_pin_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_IO][`BRC_BIT_PEN_HI:`BRC_BIT_PEN_LO] == BRC_SEL_PIN13 && pin_fall[2]
      |=> !ctl_reg[`BRC_IDX_IO][`BRC_BIT_EN])
      else $error("pin thirteen fall did not clear io enable");

   // Without pin control only writes and the sequencer may move the enable
   sel_none_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_CORE1][`BRC_BIT_PEN_HI:`BRC_BIT_PEN_LO] == BRC_SEL_NONE
      && !reg_wr && !seq_apply
      |=> $stable(ctl_reg[`BRC_IDX_CORE1][`BRC_BIT_EN]))
      else $error("core enable moved without pin control");

   // Voltage choice: rise picks A (0), fall picks B (1)
   proc_volt_a_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_PROC][`BRC_BIT_PV_HI:`BRC_BIT_PV_LO] == BRC_SEL_PIN1 && pin_rise[0]
      |=> !vsel_reg[`BRC_IDX_PROC])
      else $error("processor voltage a not chosen on rise");

   proc_volt_b_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_PROC][`BRC_BIT_PV_HI:`BRC_BIT_PV_LO] == BRC_SEL_PIN2 && pin_fall[1]
      |=> vsel_reg[`BRC_IDX_PROC])
      else $error("processor voltage b not chosen on fall");

   mem_volt_a_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_MEM][`BRC_BIT_PV_HI:`BRC_BIT_PV_LO] == BRC_SEL_PIN13 && pin_rise[2]
      |=> !vsel_reg[`BRC_IDX_MEM])
      else $error("memory voltage a not chosen on rise");

   io_volt_a_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_IO][`BRC_BIT_PV_HI:`BRC_BIT_PV_LO] == BRC_SEL_PIN13 && pin_rise[2]
      |=> !vsel_reg[`BRC_IDX_IO])
      else $error("io voltage a not chosen on rise");

   io_volt_b_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_IO][`BRC_BIT_PV_HI:`BRC_BIT_PV_LO] == BRC_SEL_PIN1 && pin_fall[0]
      |=> vsel_reg[`BRC_IDX_IO])
      else $error("io voltage b not chosen on fall");

   peri_volt_a_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctl_reg[`BRC_IDX_PERI][`BRC_BIT_PV_HI:`BRC_BIT_PV_LO] == BRC_SEL_PIN2 && pin_rise[1]
      |=> !vsel_reg[`BRC_IDX_PERI])
      else $error("peripheral voltage a not chosen on rise");

   // Output flops follow the bank and vsel_reg one cycle late
   proc_en_out_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      1'b1
      |=> buck_enable[`BRC_IDX_PROC] == $past(ctl_reg[`BRC_IDX_PROC][`BRC_BIT_EN]))
      else $error("processor enable output lags the bank");

   mem_en_out_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      1'b1
      |=> buck_enable[`BRC_IDX_MEM] == $past(ctl_reg[`BRC_IDX_MEM][`BRC_BIT_EN]))
      else $error("memory enable output lags the bank");

   io_en_out_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      1'b1
      |=> buck_enable[`BRC_IDX_IO] == $past(ctl_reg[`BRC_IDX_IO][`BRC_BIT_EN]))
      else $error("io enable output lags the bank");

   volt_out_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      1'b1
      |=> buck_select_b == $past(vsel_reg))
      else $error("voltage choice output lags its register");
endmodule : brc_regs

// ===== tb.sv
// Self-checking bench for the buck control register bank.
// Assumes brc_consts.svh and brc_pkg are compiled first; pins are driven synchronously.
`timescale 1ns/1ps
`include "brc_consts.svh"

module tb;
   import brc_pkg::*;
   logic ref_clk, arst_n, reg_wr, reg_rd, seq_apply, memory_default_supply;
   logic general_pin_one, general_pin_two, general_pin_thirteen;
   logic core_load_switch, periph_load_switch;
   brc_addr_t reg_addr;
   brc_data_t reg_wdata, reg_rdata, got, d;
   brc_vec_t buck_enable, buck_select_b;
   int failures, n_compared;
   logic [31:0] rng_state;
   brc_data_t shadow [6];

   brc_regs brc_regs_inst (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .general_pin_one, .general_pin_two, .general_pin_thirteen, .seq_apply,
      .memory_default_supply, .buck_enable, .buck_select_b, .core_load_switch,
      .periph_load_switch);

   function automatic logic [31:0] xs();
      rng_state ^= rng_state << 13;
      rng_state ^= rng_state >> 17;
      rng_state ^= rng_state << 5;
      return rng_state;
   endfunction : xs

   // Index 5 stands for the unmapped offset just past the bank
   function automatic brc_vec_t exp_en();
      brc_vec_t v;
      for (int i = 0; i < 5; i++) v[i] = shadow[i][0];
      return v;
   endfunction : exp_en

   task automatic chk_data(brc_data_t g, brc_data_t e, string m);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask : chk_data

   task automatic chk_vec(brc_vec_t g, brc_vec_t e, string m);
      chk_data({3'h0, g}, {3'h0, e}, m);
   endtask : chk_vec

   task automatic wr(int i, brc_data_t v);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= `BRC_OFS_CORE1 + 8'(i);
      reg_wdata <= v;
      if (i < 5) shadow[i] = v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(int i);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= `BRC_OFS_CORE1 + 8'(i);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 got = reg_rdata;
   endtask : rd

   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   task automatic set_pin(int s, logic v);
      @(posedge ref_clk);
      case (s)
         1: general_pin_one <= v;
         2: general_pin_two <= v;
         default: general_pin_thirteen <= v;
      endcase
   endtask : set_pin

   task automatic pulse_seq();
      @(posedge ref_clk);
      seq_apply <= 1'b1;
      @(posedge ref_clk);
      seq_apply <= 1'b0;
      tick(4);
   endtask : pulse_seq

   task automatic tally_and_finish();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Run needs about 560 cycles; this limit of 20000 cycles only catches a hang
   initial begin
      #200000;
      failures++;
      tally_and_finish();
   end

   initial begin
      {arst_n, reg_wr, reg_rd, seq_apply, memory_default_supply} = '0;
      {general_pin_one, general_pin_two, general_pin_thirteen} = '0;
      reg_addr = '0;
      reg_wdata = '0;
      rng_state = 32'hC977C1DF;
      for (int i = 0; i < 6; i++) shadow[i] = 8'h00;
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd(i);
         chk_data(got, 8'h00, "reset value");
      end
      // Random traffic with pins quiet; reserved bits must store too
      for (int k = 0; k < 40; k++) begin
         wr(xs() % 6, 8'(xs()));
         rd(xs() % 6);
      end
      wr(3, 8'h5A);
      rd(3);
      chk_data(got, 8'h5A, "write then read");
      for (int i = 0; i < 6; i++) begin
         rd(i);
         chk_data(got, shadow[i], "readback");
         tick(1);
         chk_data(reg_rdata, 8'h00, "read data idle");
      end
      tick(2);
      chk_vec(buck_enable, exp_en(), "enables");
      chk_data({6'h0, core_load_switch, periph_load_switch},
         {6'h0, shadow[0][4], shadow[4][4]}, "switches");
      for (int i = 0; i < 5; i++) wr(i, 8'h00);
      for (int b = 0; b < 5; b++) begin
         for (int s = 1; s < 4; s++) begin
            d = {1'b0, 2'(s), 2'b00, 2'(s), 1'b0};
            wr(b, d);
            set_pin(s % 3 + 1, 1'b1);
            tick(4);
            chk_vec(buck_enable, 5'h00, "wrong pin");
            set_pin(s % 3 + 1, 1'b0);
            set_pin(s, 1'b1);
            tick(4);
            chk_vec(buck_enable, 5'(1 << b), "pin rise");
            chk_vec(5'(buck_select_b[b]), 5'h00, "volt a");
            rd(b);
            chk_data(got, d | 8'h01, "pin set bit");
            set_pin(s, 1'b0);
            tick(4);
            chk_vec(buck_enable, 5'h00, "pin fall");
            chk_vec(5'(buck_select_b[b]), 5'h01, "volt b");
         end
         wr(b, 8'h00);
      end
      for (int s = 1; s < 4; s++) set_pin(s, 1'b1);
      tick(4);
      chk_vec(buck_enable, 5'h00, "no pin control");
      chk_vec(buck_select_b, 5'h1F, "no pin voltage");
      for (int i = 0; i < 5; i++) wr(i, 8'h88);
      pulse_seq();
      chk_vec(buck_enable, 5'h1B, "seq apply");
      chk_data({6'h0, core_load_switch, periph_load_switch}, 8'h03, "seq switch");
      @(posedge ref_clk);
      memory_default_supply <= 1'b1;
      pulse_seq();
      chk_vec(buck_enable, 5'h1F, "seq default");
      tally_and_finish();
   end
endmodule : tb
